// File: rtl/drcd_top.sv
// disk read command decoder: control page, read and buffer read
`timescale 1ns/1ps
`default_nettype none
`include "drcd_map.svh"
module drcd_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // command in
  input wire logic cmd_valid,
  input wire logic [79:0] cmd_cdb,
  input wire logic cmd_linked,
  output logic cmd_ready,
  // control page access
  input wire logic page_wr,
  input wire logic [47:0] page_wr_data,
  input wire logic page_rd,
  // buffer writes from the write-buffer command path
  input wire logic bufw_start,
  input wire logic bufw_valid,
  input wire logic [7:0] bufw_data,
  // log exception event in
  input wire logic log_exception_event,
  output logic log_exception_report,
  // media/cache request
  output drcd_pkg::drcd_media_req_t media_req,
  input wire logic media_done,
  // data-in stream
  output logic din_valid,
  output logic [7:0] din_data,
  input wire logic din_ready,
  // status
  output drcd_pkg::drcd_status_t status,
  output logic log_exception_report_enable,
  output logic queuing_disable_bit,
  output logic extended_allegiance_enable
);
  // ----------------------------------------------------------------
  // control page state
  // ----------------------------------------------------------------
  logic log_exc_q;
  logic [3:0] qam_q;
  logic queue_error_handling_bit_q;
  logic page_savable_flag;
  logic ready_event_permission;
  logic attention_event_permission;
  logic error_event_permission;
  logic [15:0] holdoff_period;

  assign page_savable_flag = 1'b1;
  assign queuing_disable_bit = `DRCD_BIT_RST;
  assign extended_allegiance_enable = `DRCD_BIT_RST;
  assign ready_event_permission = `DRCD_BIT_RST;
  assign attention_event_permission = `DRCD_BIT_RST;
  assign error_event_permission = `DRCD_BIT_RST;
  assign holdoff_period = 16'h0000;
  assign log_exception_report_enable = log_exc_q;

  // only changeable fields take writes; byte 2 bit 0, byte 3 bits 7:4 and 1
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      log_exc_q <= `DRCD_BIT_RST;
      qam_q <= `DRCD_QAM_RST;
      queue_error_handling_bit_q <= `DRCD_BIT_RST;
    end else if (page_wr) begin
      log_exc_q <= page_wr_data[16];
      qam_q <= page_wr_data[31:28];
      queue_error_handling_bit_q <= page_wr_data[25];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      log_exception_report <= 1'b0;
    end else begin
      log_exception_report <= log_exception_event & log_exc_q;
    end
  end

  logic [63:0] page_image;
  assign page_image = {holdoff_period[7:0], holdoff_period[15:8], 8'h00,
    extended_allegiance_enable, 4'h0, ready_event_permission,
    attention_event_permission, error_event_permission,
    qam_q, 2'h0, queue_error_handling_bit_q, queuing_disable_bit,
    7'h00, log_exc_q,
    `DRCD_PAGE_LEN,
    page_savable_flag, 1'b0, `DRCD_PAGE_CODE};

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  drcd_pkg::drcd_cmd_t cmd;
  drcd_cdb_parse u_parse (
    .cdb(cmd_cdb),
    .cmd(cmd)
  );

  drcd_pkg::drcd_state_t state_q;
  logic take;
  assign cmd_ready = (state_q == drcd_pkg::DRCD_IDLE) && !page_rd;
  assign take = cmd_valid && cmd_ready;

  // ----------------------------------------------------------------
  // buffer write tracking
  // ----------------------------------------------------------------
  logic [`DRCD_BUF_AW-1:0] wr_ptr_q;
  logic [18:0] avail_q;
  logic stale_q;
  logic miscmp_q;
  logic [`DRCD_BUF_AW-1:0] rd_addr;
  logic [7:0] mem_rd;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      avail_q <= '0;
    end else if (bufw_start) begin
      wr_ptr_q <= '0;
      avail_q <= '0;
    end else if (bufw_valid && avail_q < `DRCD_BUF_MAX) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
      avail_q <= avail_q + 1'b1;
    end
  end

  // any command after the buffer write marks the buffer suspect
  // a buffer read counts too, so a second read without a rewrite is suspect
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stale_q <= 1'b1;
      miscmp_q <= 1'b0;
    end else if (take) begin
      stale_q <= 1'b1;
      miscmp_q <= stale_q;
    end else if (bufw_start) begin
      stale_q <= 1'b0;
    end
  end

  // buffer read never writes the memory
  drcd_buf_mem u_mem (
    .sys_clk(sys_clk),
    .wr_en(bufw_valid && avail_q < `DRCD_BUF_MAX),
    .wr_addr(wr_ptr_q),
    .wr_data(bufw_data),
    .rd_addr(rd_addr),
    .rd_data(mem_rd)
  );

  // ----------------------------------------------------------------
  // read addressing
  // ----------------------------------------------------------------
  logic [31:0] last_lba_q;
  logic last_ok_q;
  logic [31:0] start_lba;

  always_comb begin
    if (cmd.relative_address_bit) begin
      start_lba = last_lba_q + cmd.lba;
    end else begin
      start_lba = cmd.lba;
    end
  end

  logic is_read;
  logic rel_bad;
  assign is_read = cmd.opcode == `DRCD_OP_READ6 || cmd.opcode == `DRCD_OP_READ10;
  assign rel_bad = cmd.relative_address_bit && !(cmd_linked && last_ok_q);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      last_lba_q <= '0;
      last_ok_q <= 1'b0;
    end else if (take) begin
      if (is_read && !rel_bad && cmd.blocks != 17'h0) begin
        last_lba_q <= start_lba + 32'(cmd.blocks) - 32'h1;
        last_ok_q <= cmd_linked;
      end else if (!cmd_linked) begin
        last_ok_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [23:0] cnt_q;
  logic [23:0] limit_q;
  logic [2:0] hidx_q;
  logic header_only_q;
  logic [31:0] hdr_q;
  logic data_first_q;
  logic beat;
  assign beat = din_valid && din_ready;
  // header bytes go first, so the buffer address trails the byte count
  assign rd_addr = cnt_q[`DRCD_BUF_AW-1:0] - {{(`DRCD_BUF_AW-3){1'b0}}, `DRCD_HDR_BYTES}
    + {{(`DRCD_BUF_AW-1){1'b0}}, beat};

  logic [18:0] data_avail;
  logic [23:0] total;
  assign data_avail = avail_q;
  // header counts toward the allocation; data capped by what is stored
  assign total = 24'(data_avail) + 24'(`DRCD_HDR_BYTES);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= drcd_pkg::DRCD_IDLE;
      media_req <= '0;
      status <= '0;
      din_valid <= 1'b0;
      din_data <= 8'h00;
      cnt_q <= '0;
      limit_q <= '0;
      hidx_q <= '0;
      header_only_q <= 1'b0;
      hdr_q <= '0;
      data_first_q <= 1'b0;
    end else begin
      status.done <= 1'b0;
      unique case (state_q)
        drcd_pkg::DRCD_IDLE: begin
          hidx_q <= '0;
          cnt_q <= '0;
          if (page_rd) begin
            limit_q <= 24'(`DRCD_PAGE_BYTES);
            state_q <= drcd_pkg::DRCD_PAGE;
          end else if (take) begin
            status.check <= 1'b0;
            status.sense_key <= `DRCD_SK_NONE;
            if (is_read) begin
              if (rel_bad) begin
                status <= '{done: 1'b1, check: 1'b1, sense_key: `DRCD_SK_ILLEGAL};
              end else if (cmd.blocks == 17'h0) begin
                status.done <= 1'b1;
              end else begin
                // fetch path keeps coherency so newest data wins
                media_req <= '{valid: 1'b1, lba: start_lba, blocks: cmd.blocks,
                  from_media: cmd.force_media_access};
                state_q <= drcd_pkg::DRCD_DONE;
              end
            end else if (cmd.opcode == `DRCD_OP_RDBUF) begin
              if (cmd.mode != `DRCD_MODE_DATA && cmd.mode != `DRCD_MODE_HDR) begin
                status <= '{done: 1'b1, check: 1'b1, sense_key: `DRCD_SK_ILLEGAL};
              end else if (cmd.alloc_len == 24'h0) begin
                status.done <= 1'b1;
              end else begin
                header_only_q <= cmd.mode == `DRCD_MODE_HDR;
                hdr_q <= {8'h00, 5'h00, data_avail};
                if (cmd.mode == `DRCD_MODE_HDR) begin
                  limit_q <= (cmd.alloc_len < 24'(`DRCD_HDR_BYTES)) ?
                    cmd.alloc_len : 24'(`DRCD_HDR_BYTES);
                end else begin
                  limit_q <= (cmd.alloc_len < total) ? cmd.alloc_len : total;
                end
                state_q <= drcd_pkg::DRCD_HDR;
              end
            end else begin
              status <= '{done: 1'b1, check: 1'b1, sense_key: `DRCD_SK_ILLEGAL};
            end
          end
        end
        drcd_pkg::DRCD_PAGE: begin
          if (!din_valid || din_ready) begin
            if (hidx_q == limit_q[2:0] && din_valid) begin
              din_valid <= 1'b0;
              status.done <= 1'b1;
              state_q <= drcd_pkg::DRCD_IDLE;
            end else if (hidx_q != limit_q[2:0] || !din_valid) begin
              din_valid <= 1'b1;
              din_data <= page_image[hidx_q*8 +: 8];
              hidx_q <= hidx_q + 3'h1;
              if (hidx_q == 3'h7) begin
                limit_q <= '0;
              end
            end
          end
        end
        drcd_pkg::DRCD_HDR: begin
          if (!din_valid || din_ready) begin
            if (cnt_q == limit_q) begin
              din_valid <= 1'b0;
              status.done <= 1'b1;
              status.check <= miscmp_q;
              status.sense_key <= miscmp_q ? `DRCD_SK_MISCMP : `DRCD_SK_NONE;
              state_q <= drcd_pkg::DRCD_IDLE;
            end else if (hidx_q < `DRCD_HDR_BYTES) begin
              din_valid <= 1'b1;
              din_data <= hdr_q[(3 - hidx_q[1:0])*8 +: 8];
              hidx_q <= hidx_q + 3'h1;
              cnt_q <= cnt_q + 24'h1;
              data_first_q <= 1'b1;
            end else begin
              state_q <= drcd_pkg::DRCD_DATA;
              din_valid <= 1'b0;
            end
          end
        end
        drcd_pkg::DRCD_DATA: begin
          // two bubble cycles per byte keep the registered read simple
          if (data_first_q) begin
            data_first_q <= 1'b0;
          end else if (!din_valid) begin
            din_valid <= 1'b1;
            din_data <= mem_rd;
          end else if (din_ready) begin
            din_valid <= 1'b0;
            cnt_q <= cnt_q + 24'h1;
            data_first_q <= 1'b1;
            if (cnt_q + 24'h1 == limit_q) begin
              status.done <= 1'b1;
              status.check <= miscmp_q;
              status.sense_key <= miscmp_q ? `DRCD_SK_MISCMP : `DRCD_SK_NONE;
              state_q <= drcd_pkg::DRCD_IDLE;
            end
          end
        end
        drcd_pkg::DRCD_DONE: begin
          media_req.valid <= 1'b0;
          if (media_done) begin
            status.done <= 1'b1;
            state_q <= drcd_pkg::DRCD_IDLE;
          end
        end
        default: begin
          state_q <= drcd_pkg::DRCD_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: rtl/drcd_map.svh
// constants for the disk read command decoder
`ifndef DRCD_MAP_SVH
`define DRCD_MAP_SVH
`define DRCD_OP_READ6 8'h08
`define DRCD_OP_READ10 8'h28
`define DRCD_OP_RDBUF 8'h3C
`define DRCD_PAGE_CODE 6'h0A
`define DRCD_PAGE_LEN 8'h06
`define DRCD_MODE_DATA 3'h0
`define DRCD_MODE_HDR 3'h3
`define DRCD_LEN6_ZERO 17'h00100
`define DRCD_HDR_BYTES 3'h4
`define DRCD_BUF_MAX 19'h40000
`define DRCD_BUF_AW 18
`define DRCD_PAGE_BYTES 4'h8
`define DRCD_QAM_RST 4'h0
`define DRCD_BIT_RST 1'h0
`define DRCD_SK_NONE 4'h0
`define DRCD_SK_ILLEGAL 4'h5
`define DRCD_SK_MISCMP 4'hE
`endif

// File: rtl/drcd_pkg.sv
// types for the disk read command decoder
package drcd_pkg;
  typedef enum logic [2:0] {
    DRCD_IDLE = 3'h0,
    DRCD_HDR = 3'h1,
    DRCD_DATA = 3'h3,
    DRCD_DONE = 3'h2,
    DRCD_PAGE = 3'h6
  } drcd_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] lun;
    logic page_out_disable;
    logic force_media_access;
    logic relative_address_bit;
    logic [31:0] lba;
    logic [16:0] blocks;
    logic [2:0] mode;
    logic [23:0] alloc_len;
  } drcd_cmd_t;

  typedef struct packed {
    logic valid;
    logic [31:0] lba;
    logic [16:0] blocks;
    logic from_media;
  } drcd_media_req_t;

  typedef struct packed {
    logic done;
    logic check;
    logic [3:0] sense_key;
  } drcd_status_t;
endpackage

// File: rtl/drcd_cdb_parse.sv
// descriptor field extraction for read and buffer read commands
`timescale 1ns/1ps
`default_nettype none
`include "drcd_map.svh"
module drcd_cdb_parse (
  // descriptor bytes, byte 0 in the low lane
  input wire logic [79:0] cdb,
  // decoded fields
  output drcd_pkg::drcd_cmd_t cmd
);
  logic [7:0] b [0:9];
  genvar i;
  generate
    for (i = 0; i < 10; i++) begin : g_byte
      assign b[i] = cdb[i*8 +: 8];
    end
  endgenerate

  always_comb begin
    cmd = '0;
    cmd.opcode = b[0];
    cmd.lun = b[1][7:5];
    cmd.mode = b[1][2:0];
    cmd.alloc_len = {b[6], b[7], b[8]};
    if (b[0] == `DRCD_OP_READ6) begin
      cmd.lba = {11'h000, b[1][4:0], b[2], b[3]};
      // zero means the full 256-block run
      cmd.blocks = (b[4] == 8'h00) ? `DRCD_LEN6_ZERO : {9'h000, b[4]};
    end else begin
      cmd.page_out_disable = b[1][4];
      cmd.force_media_access = b[1][3];
      cmd.relative_address_bit = b[1][0];
      cmd.lba = {b[2], b[3], b[4], b[5]};
      cmd.blocks = {1'b0, b[7], b[8]};
    end
  end
endmodule
`default_nettype wire

// File: rtl/drcd_buf_mem.sv
// diagnostic buffer memory, registered read
`timescale 1ns/1ps
`default_nettype none
`include "drcd_map.svh"
module drcd_buf_mem (
  // clock
  input wire logic sys_clk,
  // write port
  input wire logic wr_en,
  input wire logic [`DRCD_BUF_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [`DRCD_BUF_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:(1<<`DRCD_BUF_AW)-1];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// File: sim/drcd_properties.sv
// concurrent checks on the ports of the read command decoder
`timescale 1ns/1ps
`default_nettype none
module drcd_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // command
  input wire logic cmd_valid,
  input wire logic [79:0] cmd_cdb,
  input wire logic cmd_linked,
  input wire logic cmd_ready,
  // page and buffer write
  input wire logic page_wr,
  input wire logic [47:0] page_wr_data,
  input wire logic page_rd,
  input wire logic bufw_start,
  input wire logic bufw_valid,
  input wire logic [7:0] bufw_data,
  // events
  input wire logic log_exception_event,
  input wire logic log_exception_report,
  // media and data-in
  input wire drcd_pkg::drcd_media_req_t media_req,
  input wire logic media_done,
  input wire logic din_valid,
  input wire logic [7:0] din_data,
  input wire logic din_ready,
  // status
  input wire drcd_pkg::drcd_status_t status,
  input wire logic log_exception_report_enable,
  input wire logic queuing_disable_bit,
  input wire logic extended_allegiance_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic take;
  wire logic [7:0] op;
  wire logic long_ok;
  assign take = cmd_valid && cmd_ready;
  assign op = cmd_cdb[7:0];
  // long read, absolute address, non-zero length
  assign long_ok = take && op == 8'h28 && !cmd_cdb[8] && cmd_cdb[71:56] != 16'h0000;
  // ----
  // properties
  // ----
  property p_fixed;
    !queuing_disable_bit && !extended_allegiance_enable;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed page bit set");
  property p_rd6;
    take && op == 8'h08 |=> media_req.valid
      && media_req.lba == {11'h000, $past(cmd_cdb[12:8]), $past(cmd_cdb[23:16]), $past(cmd_cdb[31:24])}
      && media_req.blocks == ($past(cmd_cdb[39:32]) == 8'h00 ? 17'h00100 : {9'h000, $past(cmd_cdb[39:32])});
  endproperty
  a_rd6: assert property (p_rd6) else $error("short read request wrong");
  property p_rd10;
    long_ok |=> media_req.valid
      && media_req.lba == {$past(cmd_cdb[23:16]), $past(cmd_cdb[31:24]), $past(cmd_cdb[39:32]), $past(cmd_cdb[47:40])}
      && media_req.blocks == {1'h0, $past(cmd_cdb[63:56]), $past(cmd_cdb[71:64])};
  endproperty
  a_rd10: assert property (p_rd10) else $error("long read request wrong");
  property p_fua;
    long_ok |=> media_req.from_media == $past(cmd_cdb[11]);
  endproperty
  a_fua: assert property (p_fua) else $error("media access bit lost");
  property p_len10_zero;
    take && op == 8'h28 && !cmd_cdb[8] && cmd_cdb[71:56] == 16'h0000
      |=> !media_req.valid && status.done && !status.check;
  endproperty
  a_len10_zero: assert property (p_len10_zero) else $error("zero length read wrong");
  property p_media_done;
    media_done |=> status.done;
  endproperty
  a_media_done: assert property (p_media_done) else $error("no done after media");
  property p_bad_mode;
    take && op == 8'h3C && cmd_cdb[10:8] != 3'h0 && cmd_cdb[10:8] != 3'h3
      |=> status.done && status.check && status.sense_key == 4'h5 && !din_valid;
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("bad mode accepted");
  property p_rel_nolink;
    take && op == 8'h28 && cmd_cdb[8] && !cmd_linked
      |=> status.check && status.sense_key == 4'h5 && !media_req.valid;
  endproperty
  a_rel_nolink: assert property (p_rel_nolink) else $error("unlinked relative read");
  property p_log_on;
    log_exception_event && log_exception_report_enable |=> log_exception_report;
  endproperty
  a_log_on: assert property (p_log_on) else $error("log report missing");
  property p_log_off;
    log_exception_event && !log_exception_report_enable |=> !log_exception_report;
  endproperty
  a_log_off: assert property (p_log_off) else $error("log report while off");
  property p_din_hold;
    din_valid && !din_ready |=> din_valid && $stable(din_data);
  endproperty
  a_din_hold: assert property (p_din_hold) else $error("data-in beat dropped");
  c_read10: cover property (long_ok);
  c_miscmp: cover property (status.done && status.sense_key == 4'hE);
  c_page: cover property (page_rd);
endmodule
bind drcd_top drcd_properties i_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_cdb(cmd_cdb),
  .cmd_linked(cmd_linked), .cmd_ready(cmd_ready), .page_wr(page_wr),
  .page_wr_data(page_wr_data), .page_rd(page_rd), .bufw_start(bufw_start),
  .bufw_valid(bufw_valid), .bufw_data(bufw_data), .log_exception_event(log_exception_event),
  .log_exception_report(log_exception_report), .media_req(media_req),
  .media_done(media_done), .din_valid(din_valid), .din_data(din_data), .din_ready(din_ready),
  .status(status), .log_exception_report_enable(log_exception_report_enable),
  .queuing_disable_bit(queuing_disable_bit),
  .extended_allegiance_enable(extended_allegiance_enable)
);
`default_nettype wire

// File: sim/drcd_media_model.sv
// media and cache path model answering read requests
`timescale 1ns/1ps
`default_nettype none
module drcd_media_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // request and answer
  input wire drcd_pkg::drcd_media_req_t media_req,
  output logic media_done
);
  logic busy_q;
  logic [2:0] cnt_q;
  logic done_q;
  assign media_done = done_q;
  // media answers slower than cache, so both latencies get exercised
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_q <= 1'h0;
      cnt_q <= 3'h0;
      done_q <= 1'h0;
    end else begin
      done_q <= 1'h0;
      if (media_req.valid) begin
        busy_q <= 1'h1;
        cnt_q <= media_req.from_media ? 3'h5 : 3'h1;
      end else if (busy_q && cnt_q == 3'h0) begin
        busy_q <= 1'h0;
        done_q <= 1'h1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/drcd_tb_top.sv
// self-checking bench for the read command decoder
`timescale 1ns/1ps
`default_nettype none
module drcd_tb_top;
  logic sys_clk = 1'h0;
  logic sys_rst, cmd_valid, cmd_linked, page_wr, page_rd, bufw_start, bufw_valid;
  logic log_exception_event, din_ready, cmd_ready, log_exception_report, media_done;
  logic din_valid, lee, qdb, eae;
  logic [79:0] cmd_cdb;
  logic [47:0] page_wr_data;
  logic [7:0] bufw_data, din_data;
  drcd_pkg::drcd_media_req_t media_req, req_q;
  drcd_pkg::drcd_status_t status, st_q;
  int error_cnt, compares, req_n, done_n, log_n;
  logic [7:0] din_q[$];
  always #50 sys_clk = ~sys_clk;
  drcd_top i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_cdb(cmd_cdb),
    .cmd_linked(cmd_linked), .cmd_ready(cmd_ready), .page_wr(page_wr),
    .page_wr_data(page_wr_data), .page_rd(page_rd), .bufw_start(bufw_start),
    .bufw_valid(bufw_valid), .bufw_data(bufw_data), .log_exception_event(log_exception_event),
    .log_exception_report(log_exception_report), .media_req(media_req),
    .media_done(media_done), .din_valid(din_valid), .din_data(din_data), .din_ready(din_ready),
    .status(status), .log_exception_report_enable(lee), .queuing_disable_bit(qdb),
    .extended_allegiance_enable(eae)
  );
  drcd_media_model i_media (.sys_clk(sys_clk), .sys_rst(sys_rst), .media_req(media_req),
    .media_done(media_done));
  // ----
  // monitor and stalling data-in sink
  // ----
  always @(posedge sys_clk) begin
    if (media_req.valid === 1'h1) begin
      req_q = media_req;
      req_n++;
    end
    if (status.done === 1'h1) begin
      st_q = status;
      done_n++;
    end
    if (log_exception_report === 1'h1) log_n++;
    if (din_valid === 1'h1 && din_ready === 1'h1) din_q.push_back(din_data);
  end
  always @(posedge sys_clk) din_ready <= #1 ~din_ready;
  // ----
  // shared tasks
  // ----
  task wrap_up;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge sys_clk);
    #1;
  endtask
  task limit(input int i);
    if (i > 300) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task run(input logic [79:0] cdb, input logic lnk);
    int i, n0;
    n0 = done_n;
    cmd_cdb = cdb;
    cmd_linked = lnk;
    cmd_valid = 1'h1;
    for (i = 0; cmd_ready !== 1'h1; i++) begin
      tick();
      limit(i);
    end
    tick();
    cmd_valid = 1'h0;
    for (i = 0; done_n == n0; i++) begin
      tick();
      limit(i);
    end
  endtask
  task page_read(input logic [63:0] exp);
    int i;
    din_q.delete();
    page_rd = 1'h1;
    tick();
    page_rd = 1'h0;
    for (i = 0; din_q.size() < 8; i++) begin
      tick();
      limit(i);
    end
    for (i = 0; i < 8; i++) cmp(din_q[i], exp[8*i +: 8]);
  endtask
  task page_write(input logic [47:0] d);
    page_wr_data = d;
    page_wr = 1'h1;
    tick();
    page_wr = 1'h0;
    tick();
  endtask
  task log_try(input int exp);
    int n;
    n = log_n;
    log_exception_event = 1'h1;
    tick();
    log_exception_event = 1'h0;
    tick();
    tick();
    cmp(log_n - n, exp);
  endtask
  task rdbuf(input logic [79:0] cdb, input int n, input logic [71:0] exp, input logic [3:0] key);
    int i;
    din_q.delete();
    run(cdb, 1'h0);
    cmp(din_q.size(), n);
    for (i = 0; i < n && i < din_q.size(); i++) cmp(din_q[i], exp[8*i +: 8]);
    cmp(st_q.sense_key, key);
    cmp(st_q.check, key != 4'h0);
  endtask
  // ----
  // scenarios
  // ----
  task t_reset;
    cmp(cmd_ready, 1'h1);
    cmp({lee, qdb, eae}, 3'h0);
  endtask
  task t_page;
    page_read(64'h000000000000068A);
    page_write(48'h00FFF3010000);
    page_read(64'h00000000F201068A);
    cmp(lee, 1'h1);
    log_try(1);
    page_write(48'h000000000000);
    cmp(lee, 1'h0);
    log_try(0);
  endtask
  task t_reads;
    logic f;
    int n;
    n = req_n;
    run(80'h00000000000034123F08, 1'h0);
    cmp(req_n - n, 1);
    cmp(req_q.lba, 32'h001F1234);
    cmp(req_q.blocks, 17'h00100);
    for (int k = 0; k < 2; k++) begin
      f = k[0];
      // page-out disable kept at zero by the initiator
      run(80'h00020100EFCDAB890028 | {68'h0, f, 11'h000}, 1'h0);
      cmp(req_q.lba, 32'h89ABCDEF);
      cmp(req_q.blocks, 17'h00102);
      cmp(req_q.from_media, f);
      cmp(st_q.check, 1'h0);
    end
    n = req_n;
    run(80'h00000000EFCDAB890028, 1'h0);
    cmp(st_q.check, 1'h0);
    run(80'h00010000100000000128, 1'h0);
    cmp({st_q.check, st_q.sense_key}, 5'h15);
    cmp(req_n - n, 0);
    run(80'h00020000000100000028, 1'h1);
    run(80'h00010000FFFFFFFF0128, 1'h1);
    cmp(req_q.lba, 32'h00000100);
  endtask
  task t_buf;
    bufw_start = 1'h1;
    tick();
    bufw_start = 1'h0;
    bufw_valid = 1'h1;
    for (int i = 0; i < 5; i++) begin
      bufw_data = 8'hA0 + 8'(i);
      tick();
    end
    bufw_valid = 1'h0;
    // no command between write and first read keeps the test reliable
    rdbuf(80'h0006000000000000003C, 6, 72'hA1A005000000, 4'h0);
    rdbuf(80'h000A000000000000033C, 4, 72'h05000000, 4'hE);
    rdbuf(80'h0010000000000000003C, 9, 72'hA4A3A2A1A005000000, 4'hE);
    rdbuf(80'h000A000000000000013C, 0, 72'h0, 4'h5);
    bufw_start = 1'h1;
    tick();
    bufw_start = 1'h0;
    rdbuf(80'h0000000000000000003C, 0, 72'h0, 4'h0);
  endtask
  initial begin
    {sys_rst, cmd_valid, cmd_linked, page_wr, page_rd, bufw_start, bufw_valid} = 7'h40;
    {log_exception_event, din_ready} = 2'h0;
    cmd_cdb = 80'h0;
    page_wr_data = 48'h0;
    bufw_data = 8'h00;
    repeat (20) @(posedge sys_clk);
    #1;
    sys_rst = 1'h0;
    t_reset();
    t_page();
    t_reads();
    t_buf();
    wrap_up();
  end
endmodule
`default_nettype wire
